// ===== hw/csr_consts.vh
// Register offsets, field positions, reset values and timing counts
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// ********************
// Register offsets
// ********************
`define OFS_CTRL       8'h00
`define OFS_SLEEP_CMD  8'h01
`define OFS_STATUS     8'h02
`define OFS_PORT_OUT   8'h04
`define OFS_PORT_DIR   8'h08
`define OFS_PORT_PIN   8'h0c

// ********************
// Control fields
// ********************
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_SLEEP_EN  2
`define CTRL_ADC_EN    3
`define CTRL_RESET     8'h00

// ********************
// Sleep mode codes
// ********************
`define MODE_IDLE      2'h0
`define MODE_ADCNR     2'h1
`define MODE_PDOWN     2'h2
`define MODE_PSAVE     2'h3

// ********************
// Clock source fuse codes
// ********************
`define FUSE_XTAL_MIN  4'ha
`define FUSE_LFX_MIN   4'h8
`define FUSE_RCX_MIN   4'h5
`define FUSE_IRC_MIN   4'h2
`define FUSE_FACTORY   4'h2

// ********************
// Timing
// ********************
`define CLK_MHZ        200
`define RST_MIN_NS     500
`define RST_CYC        ((`RST_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== hw/clock_sleep_reset_control.v
// Clock source selection, sleep gating, reset filter and port pins
// Operation
// [R1] Idle: core halted; memory, timers, serial port, interrupts keep clock.
// [R2] Power-down: oscillator and all functions stop until interrupt or reset.
// [R3] Power-save: asynchronous timer oscillator and its timer keep running.
// [R4] Converter noise-reduction: only async timer and converter stay clocked.
// [R5] Reset pin low longer than 500 ns resets the device.
// [R6] Any reset releases all four ports to high impedance at once.
// [R7] Fuse codes pick crystal, low-frequency crystal or external RC.
// [R8] Fuse codes pick internal RC or external clock; programmed bit is 0.
// [R9] Factory default source is the internal 1 MHz RC oscillator.
// [R10] Port A feeds the converter, else serves as 8-bit general port.
// [R11] Every port bit has its own switchable pull-up.
// [R12] Fuse field sampled in reset; source never changes while running.
`timescale 1ns/1ps
`default_nettype none
`include "csr_consts.vh"

module clock_sleep_reset_control #(
   parameter RST_CYC = `RST_CYC
) (
   input  wire       I_CLK,
   input  wire       I_RSTN,
   input  wire       I_EXT_RESET_N,
   input  wire [3:0] I_CLK_FUSE,
   input  wire       I_WAKE,
   input  wire [7:0] I_ADDR,
   input  wire [7:0] I_WDATA,
   input  wire       I_WE,
   input  wire       I_RE,
   output wire [7:0] O_RDATA,
   input  wire [7:0] I_PORT_A,
   input  wire [7:0] I_PORT_B,
   input  wire [7:0] I_PORT_C,
   input  wire [7:0] I_PORT_D,
   output wire [7:0] O_PORT_A,
   output wire [7:0] O_PORT_B,
   output wire [7:0] O_PORT_C,
   output wire [7:0] O_PORT_D,
   output wire [7:0] O_PORT_A_OE_N,
   output wire [7:0] O_PORT_B_OE_N,
   output wire [7:0] O_PORT_C_OE_N,
   output wire [7:0] O_PORT_D_OE_N,
   output wire [7:0] O_PORT_A_PU,
   output wire [7:0] O_PORT_B_PU,
   output wire [7:0] O_PORT_C_PU,
   output wire [7:0] O_PORT_D_PU,
   output wire       O_ADC_PATH_EN,
   output wire [4:0] O_CLK_SRC,
   output wire       O_CORE_RST_N,
   output wire       O_CPU_CLK_EN,
   output wire       O_IO_CLK_EN,
   output wire       O_ADC_CLK_EN,
   output wire       O_ASYNC_TMR_EN,
   output wire       O_MAIN_OSC_EN,
   output wire       O_SLEEPING
);

   // ********************
   // Sleep states
   // ********************
   localparam [4:0] ST_ACTIVE = 5'h01;
   localparam [4:0] ST_IDLE   = 5'h02;
   localparam [4:0] ST_ADCNR  = 5'h04;
   localparam [4:0] ST_PDOWN  = 5'h08;
   localparam [4:0] ST_PSAVE  = 5'h10;

   // ********************
   // Functions
   // ********************
   // One-hot source: 4 crystal, 3 low-freq, 2 ext RC, 1 int RC, 0 ext clock
   function [4:0] fuse_decode;
      input [3:0] f;
      begin
         if (f >= `FUSE_XTAL_MIN)
            fuse_decode = 5'h10;
         else if (f >= `FUSE_LFX_MIN)
            fuse_decode = 5'h08;
         else if (f >= `FUSE_RCX_MIN)
            fuse_decode = 5'h04;
         else if (f >= `FUSE_IRC_MIN)
            fuse_decode = 5'h02;
         else
            fuse_decode = 5'h01;
      end
   endfunction

   function [7:0] pin_oe_n;
      input [7:0] dir;
      input       off;
      begin
         pin_oe_n = off ? 8'hff : ~dir;
      end
   endfunction

   // Pull-up on an input bit whose output latch holds one
   function [7:0] pin_pu;
      input [7:0] dir;
      input [7:0] dat;
      input       off;
      begin
         pin_pu = off ? 8'h00 : (~dir & dat);
      end
   endfunction

   // ********************
   // Reset pin filter
   // ********************
   reg       ext_s1_reg;
   reg       ext_s2_reg;
   reg [7:0] low_cnt_reg;
   reg       ext_rst_reg;
   wire      rst_n;

   // Filter runs off I_RSTN only, so it holds its count and output while it resets
   always @(posedge I_CLK) begin
      ext_s1_reg <= I_EXT_RESET_N;
      ext_s2_reg <= ext_s1_reg;
      if (!I_RSTN) begin
         low_cnt_reg <= 8'h00;
         ext_rst_reg <= 1'b0;
      end else if (ext_s2_reg) begin
         low_cnt_reg <= 8'h00;
         ext_rst_reg <= 1'b0;
      end else if (low_cnt_reg >= RST_CYC[7:0] - 8'h01) begin
         ext_rst_reg <= 1'b1; // see [R5]
      end else begin
         low_cnt_reg <= low_cnt_reg + 8'h01;
      end
   end

   assign rst_n = I_RSTN & ~ext_rst_reg;

   reg core_rst_n_reg;
   always @(posedge I_CLK) begin
      core_rst_n_reg <= rst_n;
   end
   assign O_CORE_RST_N = core_rst_n_reg;

   // ********************
   // Clock source fuse
   // ********************
   reg [3:0] fuse_s1_reg;
   reg [3:0] fuse_s2_reg;
   reg [4:0] clk_src_reg;

   // Captured only while reset is held; no switching on the fly
   always @(posedge I_CLK) begin
      fuse_s1_reg <= I_CLK_FUSE;
      fuse_s2_reg <= fuse_s1_reg;
      if (!rst_n)
         clk_src_reg <= fuse_decode(fuse_s2_reg); // see [R7] see [R8] see [R12]
   end
   assign O_CLK_SRC = clk_src_reg;

   // ********************
   // Pin and wake synchronisers
   // ********************
   reg [31:0] pin_s1_reg;
   reg [31:0] pin_s2_reg;
   reg        wake_s1_reg;
   reg        wake_s2_reg;

   always @(posedge I_CLK) begin
      pin_s1_reg  <= {I_PORT_D, I_PORT_C, I_PORT_B, I_PORT_A};
      pin_s2_reg  <= pin_s1_reg;
      wake_s1_reg <= I_WAKE;
      wake_s2_reg <= wake_s1_reg;
   end

   // ********************
   // Registers
   // ********************
   reg [7:0] ctrl_reg;
   reg [7:0] out_reg [0:3];
   reg [7:0] dir_reg [0:3];
   reg [7:0] rdata_reg;
   reg [4:0] state_reg;
   reg [4:0] state_next;
   reg [7:0] rd_mux;
   wire      sleep_go;
   wire [1:0] mode;
   wire      adc_en;
   integer   i;

   assign mode   = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign adc_en = ctrl_reg[`CTRL_ADC_EN];
   assign sleep_go = I_WE && (I_ADDR == `OFS_SLEEP_CMD)
                     && ctrl_reg[`CTRL_SLEEP_EN];

   always @(posedge I_CLK) begin
      if (!rst_n) begin
         ctrl_reg <= `CTRL_RESET;
         for (i = 0; i < 4; i = i + 1) begin
            out_reg[i] <= 8'h00;
            dir_reg[i] <= 8'h00;
         end
      end else if (I_WE) begin
         if (I_ADDR == `OFS_CTRL)
            ctrl_reg <= I_WDATA;
         for (i = 0; i < 4; i = i + 1) begin
            if (I_ADDR == `OFS_PORT_OUT + i[7:0])
               out_reg[i] <= I_WDATA; // see [R11]
            if (I_ADDR == `OFS_PORT_DIR + i[7:0])
               dir_reg[i] <= I_WDATA;
         end
      end
   end

   always @* begin
      rd_mux = 8'h00;
      case (I_ADDR)
         `OFS_CTRL:
            rd_mux = ctrl_reg;
         `OFS_STATUS:
            rd_mux = {state_reg != ST_ACTIVE, 2'h0, clk_src_reg};
         `OFS_PORT_OUT:
            rd_mux = out_reg[0];
         `OFS_PORT_OUT + 8'h01:
            rd_mux = out_reg[1];
         `OFS_PORT_OUT + 8'h02:
            rd_mux = out_reg[2];
         `OFS_PORT_OUT + 8'h03:
            rd_mux = out_reg[3];
         `OFS_PORT_DIR:
            rd_mux = dir_reg[0];
         `OFS_PORT_DIR + 8'h01:
            rd_mux = dir_reg[1];
         `OFS_PORT_DIR + 8'h02:
            rd_mux = dir_reg[2];
         `OFS_PORT_DIR + 8'h03:
            rd_mux = dir_reg[3];
         `OFS_PORT_PIN:
            rd_mux = pin_s2_reg[7:0];
         `OFS_PORT_PIN + 8'h01:
            rd_mux = pin_s2_reg[15:8];
         `OFS_PORT_PIN + 8'h02:
            rd_mux = pin_s2_reg[23:16];
         `OFS_PORT_PIN + 8'h03:
            rd_mux = pin_s2_reg[31:24];
         default:
            rd_mux = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge I_CLK) begin
      if (!rst_n)
         rdata_reg <= 8'h00;
      else if (I_RE)
         rdata_reg <= rd_mux;
      else
         rdata_reg <= 8'h00;
   end
   assign O_RDATA = rdata_reg;

   // ********************
   // Sleep state machine
   // ********************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: begin
            if (sleep_go) begin
               case (mode)
                  `MODE_IDLE:
                     state_next = ST_IDLE;
                  `MODE_ADCNR:
                     state_next = ST_ADCNR;
                  `MODE_PDOWN:
                     state_next = ST_PDOWN;
                  default:
                     state_next = ST_PSAVE;
               endcase
            end
         end
         ST_IDLE, ST_ADCNR, ST_PDOWN, ST_PSAVE: begin
            if (wake_s2_reg)
               state_next = ST_ACTIVE; // see [R2]
         end
         default:
            state_next = ST_ACTIVE;
      endcase
   end

   reg cpu_en_reg;
   reg io_en_reg;
   reg adc_clk_reg;
   reg tmr_en_reg;
   reg osc_en_reg;

   // Enables are registered from the next state so they glitch-free gate clocks
   always @(posedge I_CLK) begin
      if (!rst_n) begin
         state_reg   <= ST_ACTIVE;
         cpu_en_reg  <= 1'b1;
         io_en_reg   <= 1'b1;
         adc_clk_reg <= 1'b1;
         tmr_en_reg  <= 1'b1;
         osc_en_reg  <= 1'b1;
      end else begin
         state_reg   <= state_next;
         cpu_en_reg  <= (state_next == ST_ACTIVE); // see [R1] see [R4]
         io_en_reg   <= (state_next == ST_ACTIVE)
                        || (state_next == ST_IDLE); // see [R1]
         adc_clk_reg <= (state_next == ST_ACTIVE)
                        || (state_next == ST_IDLE)
                        || (state_next == ST_ADCNR); // see [R4]
         tmr_en_reg  <= (state_next != ST_PDOWN); // see [R3] see [R2]
         osc_en_reg  <= (state_next != ST_PDOWN)
                        && (state_next != ST_PSAVE); // see [R2]
      end
   end

   assign O_CPU_CLK_EN   = cpu_en_reg;
   assign O_IO_CLK_EN    = io_en_reg;
   assign O_ADC_CLK_EN   = adc_clk_reg;
   assign O_ASYNC_TMR_EN = tmr_en_reg;
   assign O_MAIN_OSC_EN  = osc_en_reg;
   assign O_SLEEPING     = ~cpu_en_reg;

   // ********************
   // Port pins
   // ********************
   // Raw pin and reset term: pins release at once, with no clock needed
   wire rst_any;
   wire a_off;
   assign rst_any = ~I_EXT_RESET_N | ~rst_n; // see [R6]
   assign a_off   = rst_any | adc_en; // see [R10]

   assign O_ADC_PATH_EN = adc_en; // see [R10]

   assign O_PORT_A = out_reg[0];
   assign O_PORT_B = out_reg[1];
   assign O_PORT_C = out_reg[2];
   assign O_PORT_D = out_reg[3];

   assign O_PORT_A_OE_N = pin_oe_n(dir_reg[0], a_off); // see [R6] see [R10]
   assign O_PORT_B_OE_N = pin_oe_n(dir_reg[1], rst_any); // see [R6]
   assign O_PORT_C_OE_N = pin_oe_n(dir_reg[2], rst_any); // see [R6]
   assign O_PORT_D_OE_N = pin_oe_n(dir_reg[3], rst_any); // see [R6]

   assign O_PORT_A_PU = pin_pu(dir_reg[0], out_reg[0], a_off); // see [R11]
   assign O_PORT_B_PU = pin_pu(dir_reg[1], out_reg[1], rst_any); // see [R11]
   assign O_PORT_C_PU = pin_pu(dir_reg[2], out_reg[2], rst_any); // see [R11]
   assign O_PORT_D_PU = pin_pu(dir_reg[3], out_reg[3], rst_any); // see [R11]

   // Factory parts carry the internal RC code; see FUSE_FACTORY. see [R9]

endmodule
`default_nettype wire

// ===== tb/csrc_asserts.sv
// Checker for sleep gating, reset and port release outputs
`timescale 1ns/1ps
`default_nettype none
module csrc_asserts #(
   parameter RST_CYC = 100
) (
   input wire logic       I_CLK,
   input wire logic       I_RSTN,
   input wire logic       I_EXT_RESET_N,
   input wire logic       I_WAKE,
   input wire logic [7:0] O_PORT_A_OE_N,
   input wire logic [7:0] O_PORT_B_OE_N,
   input wire logic [7:0] O_PORT_D_OE_N,
   input wire logic [7:0] O_PORT_A_PU,
   input wire logic [7:0] O_PORT_B_PU,
   input wire logic       O_ADC_PATH_EN,
   input wire logic [4:0] O_CLK_SRC,
   input wire logic       O_CORE_RST_N,
   input wire logic       O_CPU_CLK_EN,
   input wire logic       O_IO_CLK_EN,
   input wire logic       O_ADC_CLK_EN,
   input wire logic       O_ASYNC_TMR_EN,
   input wire logic       O_MAIN_OSC_EN,
   input wire logic       O_SLEEPING
);
   // ****************
   // Properties
   // ****************
   // Length of the current low on the reset pin, saturating
   logic [7:0] low_cnt;
   always @(posedge I_CLK) begin
      low_cnt <= I_EXT_RESET_N ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   AST_PIN_RELEASE: assert property (
      !I_EXT_RESET_N |-> (O_PORT_A_OE_N & O_PORT_B_OE_N & O_PORT_D_OE_N) == 8'hff)
      else $error("ports driven during reset");
   AST_LONG_RESET: assert property (
      low_cnt > RST_CYC + 4 |-> !O_CORE_RST_N)
      else $error("long reset low ignored");
   AST_IDLE: assert property (
      O_SLEEPING && O_IO_CLK_EN |-> O_ADC_CLK_EN && O_ASYNC_TMR_EN && O_MAIN_OSC_EN)
      else $error("idle stopped a domain");
   AST_PDOWN: assert property (
      !O_ASYNC_TMR_EN |-> !(O_CPU_CLK_EN | O_IO_CLK_EN | O_ADC_CLK_EN | O_MAIN_OSC_EN))
      else $error("power-down left a domain on");
   AST_PSAVE: assert property (
      O_ASYNC_TMR_EN && !O_MAIN_OSC_EN |-> !(O_CPU_CLK_EN | O_IO_CLK_EN | O_ADC_CLK_EN))
      else $error("power-save mix wrong");
   AST_ADCNR: assert property (
      O_SLEEPING && !O_IO_CLK_EN && O_ADC_CLK_EN |-> O_ASYNC_TMR_EN && O_MAIN_OSC_EN)
      else $error("noise mode mix wrong");
   AST_WAKE: assert property (
      I_WAKE && O_SLEEPING |-> ##[1:4] !O_SLEEPING)
      else $error("wake not taken");
   AST_SRC_HOLD: assert property (
      O_CORE_RST_N && $past(O_CORE_RST_N) |-> $stable(O_CLK_SRC))
      else $error("source moved while running");
   AST_ONEHOT: assert property (
      O_CORE_RST_N |-> $onehot(O_CLK_SRC))
      else $error("source not one-hot");
   AST_ADC_PATH: assert property (
      O_ADC_PATH_EN |-> O_PORT_A_OE_N == 8'hff && O_PORT_A_PU == 8'h00)
      else $error("port A not given to converter");
   AST_PU_INPUT: assert property (
      (O_PORT_B_PU & ~O_PORT_B_OE_N) == 8'h00)
      else $error("pull-up on driven bit");
   COV_PDOWN: cover property (!O_ASYNC_TMR_EN);
   COV_PSAVE: cover property (O_ASYNC_TMR_EN && !O_MAIN_OSC_EN);
   COV_EXT_RST: cover property (!I_EXT_RESET_N ##1 !O_CORE_RST_N);
endmodule
bind clock_sleep_reset_control csrc_asserts #(.RST_CYC(RST_CYC)) i_chk (
   .I_CLK          (I_CLK),
   .I_RSTN         (I_RSTN),
   .I_EXT_RESET_N  (I_EXT_RESET_N),
   .I_WAKE         (I_WAKE),
   .O_PORT_A_OE_N  (O_PORT_A_OE_N),
   .O_PORT_B_OE_N  (O_PORT_B_OE_N),
   .O_PORT_D_OE_N  (O_PORT_D_OE_N),
   .O_PORT_A_PU    (O_PORT_A_PU),
   .O_PORT_B_PU    (O_PORT_B_PU),
   .O_ADC_PATH_EN  (O_ADC_PATH_EN),
   .O_CLK_SRC      (O_CLK_SRC),
   .O_CORE_RST_N   (O_CORE_RST_N),
   .O_CPU_CLK_EN   (O_CPU_CLK_EN),
   .O_IO_CLK_EN    (O_IO_CLK_EN),
   .O_ADC_CLK_EN   (O_ADC_CLK_EN),
   .O_ASYNC_TMR_EN (O_ASYNC_TMR_EN),
   .O_MAIN_OSC_EN  (O_MAIN_OSC_EN),
   .O_SLEEPING     (O_SLEEPING)
);
`default_nettype wire

// ===== tb/board_model.sv
// Board around the device: reset pin source and port pin loads
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input  wire logic [31:0] i_oe_n,
   input  wire logic [31:0] i_pu,
   input  wire logic [31:0] i_dout,
   input  wire logic [31:0] i_ext,
   input  wire logic [31:0] i_ext_en,
   output var  logic [31:0] o_pins,
   output var  logic        o_reset_n
);
   // ****************
   // Pin resolution
   // ****************
   logic [31:0] held = 32'h0;
   wire  [31:0] drv;
   wire  [31:0] flt;
   // A bit is driven by the device, by the board, or lifted by its pull-up
   assign drv = ~i_oe_n & i_dout | i_oe_n & i_ext_en & i_ext
                | i_oe_n & ~i_ext_en & i_pu;
   assign flt = i_oe_n & ~i_ext_en & ~i_pu;
   // Held level follows only driven bits, so a floating bit shows the
   // inverse of its last level and keeps it, with no zero-delay loop
   always @(drv, flt) begin
      for (int b = 0; b < 32; b++) begin
         if (flt[b] === 1'b0)
            held[b] <= drv[b];
      end
   end
   always @* begin
      o_pins = drv & ~flt | ~held & flt;
   end
   initial o_reset_n = 1'b1;
   // The board holds the pin low for the whole span asked for
   task pulse(input int ns);
      o_reset_n = 1'b0;
      #(ns);
      o_reset_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== tb/clock_sleep_reset_control_test.sv
// Self-checking bench for clock, sleep and reset control
`timescale 1ns/1ps
`default_nettype none
module clock_sleep_reset_control_test;
   logic I_CLK = 0, I_RSTN = 0, I_WAKE = 0, I_WE = 0, I_RE = 0;
   logic [3:0] I_CLK_FUSE = 4'h2;
   logic [7:0] I_ADDR = 8'h00, I_WDATA = 8'h00, d;
   logic [31:0] oe_n, pu, dout, pins, ext = 32'h0, ext_en = 32'h0;
   wire [7:0] O_RDATA;
   wire [4:0] O_CLK_SRC;
   wire cpu, io, adc, tmr, osc, core_n, ext_n, adc_path, slp;
   int fail_count = 0, n_checks = 0;
   always #2.5 I_CLK = ~I_CLK;
   clock_sleep_reset_control i_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_EXT_RESET_N(ext_n),
      .I_CLK_FUSE(I_CLK_FUSE), .I_WAKE(I_WAKE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WE(I_WE),
      .I_RE(I_RE), .O_RDATA(O_RDATA), .I_PORT_A(pins[7:0]), .I_PORT_B(pins[15:8]),
      .I_PORT_C(pins[23:16]), .I_PORT_D(pins[31:24]), .O_PORT_A(dout[7:0]), .O_PORT_B(dout[15:8]),
      .O_PORT_C(dout[23:16]), .O_PORT_D(dout[31:24]), .O_PORT_A_OE_N(oe_n[7:0]),
      .O_PORT_B_OE_N(oe_n[15:8]), .O_PORT_C_OE_N(oe_n[23:16]), .O_PORT_D_OE_N(oe_n[31:24]),
      .O_PORT_A_PU(pu[7:0]), .O_PORT_B_PU(pu[15:8]), .O_PORT_C_PU(pu[23:16]),
      .O_PORT_D_PU(pu[31:24]), .O_ADC_PATH_EN(adc_path), .O_CLK_SRC(O_CLK_SRC),
      .O_CORE_RST_N(core_n), .O_CPU_CLK_EN(cpu), .O_IO_CLK_EN(io), .O_ADC_CLK_EN(adc),
      .O_ASYNC_TMR_EN(tmr), .O_MAIN_OSC_EN(osc), .O_SLEEPING(slp));
   board_model i_board (.i_oe_n(oe_n), .i_pu(pu), .i_dout(dout), .i_ext(ext),
      .i_ext_en(ext_en), .o_pins(pins), .o_reset_n(ext_n));
   // ****************
   // Shared tasks
   // ****************
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge I_CLK);
      I_WE <= 1; I_ADDR <= a; I_WDATA <= v;
      @(posedge I_CLK);
      I_WE <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge I_CLK);
      I_RE <= 1; I_ADDR <= a;
      @(posedge I_CLK);
      I_RE <= 0;
      #1 d = O_RDATA;
   endtask
   task do_reset;
      @(posedge I_CLK);
      I_RSTN <= 0;
      cyc(4);
      I_RSTN <= 1;
      cyc(3);
   endtask
   function logic [4:0] src_of(input logic [3:0] f);
      return f >= 4'ha ? 5'h10 : f >= 4'h8 ? 5'h08 : f >= 4'h5 ? 5'h04 : f >= 4'h2 ? 5'h02 : 5'h01;
   endfunction
   // ****************
   // Scenarios
   // ****************
   task t_fuse;
      for (int f = 0; f < 16; f++) begin
         I_CLK_FUSE <= f[3:0];
         do_reset();
         chk("clk_src", O_CLK_SRC, src_of(f[3:0]));
         I_CLK_FUSE <= ~f[3:0];
         cyc(4);
         chk("clk_src_held", O_CLK_SRC, src_of(f[3:0]));
      end
      I_CLK_FUSE <= 4'h2;
      do_reset();
      chk("factory_src", O_CLK_SRC, 5'h02);
      $display("test fuse done");
   endtask
   task t_sleep;
      logic [4:0] tbl [4];
      tbl = '{5'h0f, 5'h07, 5'h00, 5'h02};
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h00);
      cyc(2);
      chk("refused", {cpu, io, adc, tmr, osc}, 5'h1f);
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 8'h04 | m[7:0]);
         wr(8'h01, 8'h00);
         cyc(2);
         chk("sleep_en", {cpu, io, adc, tmr, osc}, tbl[m]);
         chk("sleeping", slp, 8'h01);
         rd(8'h02);
         chk("status", d, 8'h82);
         I_WAKE <= 1;
         cyc(5);
         chk("woken", {cpu, io, adc, tmr, osc}, 5'h1f);
         I_WAKE <= 0;
         cyc(2);
      end
      $display("test sleep done");
   endtask
   task t_ports;
      ext[15:8] <= 8'h80;
      ext_en[15:8] <= 8'hc0;
      wr(8'h09, 8'h0f);
      wr(8'h05, 8'h3c);
      wr(8'h06, 8'h80);
      wr(8'h0a, 8'h01);
      cyc(1);
      chk("oe_n_b", oe_n[15:8], 8'hf0);
      chk("pu_b", pu[15:8], 8'h30);
      chk("oe_n_c", oe_n[23:16], 8'hfe);
      chk("pu_c", pu[23:16], 8'h80);
      cyc(3);
      rd(8'h0d);
      chk("pin_b", d, 8'hbc);
      rd(8'h03);
      chk("unmapped", d, 8'h00);
      wr(8'h08, 8'hff);
      wr(8'h00, 8'h08);
      cyc(1);
      chk("adc_path", adc_path, 1'b1);
      chk("oe_n_a", oe_n[7:0], 8'hff);
      wr(8'h00, 8'h00);
      cyc(1);
      chk("oe_n_a_gp", oe_n[7:0], 8'h00);
      $display("test ports done");
   endtask
   task t_extrst;
      wr(8'h0b, 8'hff);
      cyc(1);
      fork
         i_board.pulse(300);
         begin
            #50;
            chk("oe_n_d_short", oe_n[31:24], 8'hff);
            chk("oe_n_c_short", oe_n[23:16], 8'hff);
         end
      join
      cyc(5);
      chk("short_core", core_n, 8'h01);
      chk("short_oe_n_d", oe_n[31:24], 8'h00);
      fork
         i_board.pulse(700);
         begin #650 chk("core_rst", core_n, 1'b0); end
      join
      cyc(5);
      chk("dir_cleared", oe_n[31:24], 8'hff);
      $display("test ext reset done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      do_reset();
      t_fuse();
      t_sleep();
      t_ports();
      t_extrst();
      finish_test();
   end
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
